// ===== hdl/uisc_pkg.sv
// package: offsets, unlock values, field positions for the status/clear block
package uisc_pkg;
  localparam logic [3:0] UISC_OFS_LINE_CTRL = 4'h3;
  localparam logic [3:0] UISC_OFS_SPECIAL_FN = 4'h7;
  localparam logic [3:0] UISC_OFS_STATUS_CLR = 4'hf;
  localparam logic [7:0] UISC_UNLOCK_VAL = 8'hbf;
  localparam int UISC_SFN_ENABLE_BIT = 2;
  localparam int UISC_CLR_ALL_BIT = 0;
  localparam logic [7:0] UISC_STATUS_RESET = 8'h00;
  localparam logic [7:0] UISC_LCR_RESET = 8'h00;
  localparam logic [7:0] UISC_SFN_RESET = 8'h00;
  localparam int UISC_NUM_SRC = 7;
  localparam logic [7:0] UISC_RD_ZERO = 8'h00;
endpackage

// ===== hdl/uisc_if.sv
// interface: source events between top and flag bank
`timescale 1ns/1ps
interface uisc_if;
  logic [6:0] src_active;
  logic [6:0] src_serviced;
  logic clear_all;
  logic [6:0] flags;
  modport top (output src_active, output src_serviced, output clear_all,
    input flags);
  modport bank (input src_active, input src_serviced, input clear_all,
    output flags);
endinterface

// ===== hdl/uisc_flag_bank.sv
// sticky interrupt status flags, bits 7..1 of the status register
`timescale 1ns/1ps
module uisc_flag_bank
  import uisc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  uisc_if.bank bus
);
  logic [6:0] flags;
  logic [6:0] next_flags;
  logic [6:0] src_q;

  ////////////////////////////////////////////////////////////////////////////
  // rising edge of a source sets its flag; set beats clear
  always_comb begin
    next_flags = flags;
    if (bus.clear_all) begin
      next_flags = '0; // R10
    end
    next_flags = next_flags & ~bus.src_serviced; // R13
    next_flags = next_flags | (bus.src_active & ~src_q); // R13
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags <= UISC_STATUS_RESET[7:1];
      src_q <= 7'h00;
    end else begin
      flags <= next_flags;
      src_q <= bus.src_active;
    end
  end

  assign bus.flags = flags;

  ////////////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (bus.src_active[0] && !src_q[0]) |=> flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set) // R13
    else $error("flag did not set on source edge");

  property p_clear_all;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (bus.clear_all && ((bus.src_active & ~src_q) == 7'h00)) |=>
        (flags == 7'h00);
  endproperty
  a_clear_all: assert property (p_clear_all) // R10
    else $error("clear-all left a flag set");

  property p_flag_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (flags[3] && !bus.clear_all && !bus.src_serviced[3]) |=> flags[3];
  endproperty
  a_flag_hold: assert property (p_flag_hold) // R13
    else $error("flag dropped without clear");

  c_clear: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    bus.clear_all && (flags != 7'h00));
endmodule // uisc_flag_bank

// ===== hdl/uisc_status_clear.sv
// interrupt status and clear register of one bridge channel
`timescale 1ns/1ps
// Function
// R1: register visible only when line control holds 0xBF and enable bit set.
// R2: register at offset 0x0F, eight bits, zero after reset.
// R3: bit 7 shows CTS/RTS change interrupt active.
// R4: bit 6 shows received flow-off or special character interrupt active.
// R5: bit 5 shows modem status interrupt active.
// R6: bit 4 shows transmit holding interrupt active.
// R7: bit 3 shows receiver timeout interrupt active.
// R8: bit 2 shows receive holding data-available interrupt active.
// R9: bit 1 shows receive line error interrupt active.
// R10: writing one to bit 0 clears every status flag; the code keeps any flag whose source rises in the clearing cycle.
// R11: clear-all bit returns to zero by itself after the write.
// R12: special function bit 2 enables special register access when unlocked.
// R13: flag sets on source activation, holds until serviced or cleared.
module uisc_status_clear
  import uisc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic cts_rts_change_i,
  input wire logic flow_off_special_i,
  input wire logic modem_i,
  input wire logic transmit_holding_i,
  input wire logic rx_timeout_i,
  input wire logic receive_holding_i,
  input wire logic line_error_i,
  input wire logic [6:0] serviced_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] interrupt_status_clear_o,
  output logic special_access_o
);
  logic [7:0] line_control_reg;
  logic [7:0] special_function_reg;
  logic clear_all_status;
  logic [7:0] reg_rdata;
  logic [7:0] next_line_control_reg;
  logic [7:0] next_special_function_reg;
  logic next_clear_all_status;
  logic [7:0] next_reg_rdata;
  logic unlocked;
  logic [7:0] status_view;
  logic clr_req;

  uisc_if link ();

  ////////////////////////////////////////////////////////////////////////////
  // sources in bit order 7..1 packed into 6..0
  assign link.src_active = {cts_rts_change_i, // R3
                            flow_off_special_i, // R4
                            modem_i, // R5
                            transmit_holding_i, // R6
                            rx_timeout_i, // R7
                            receive_holding_i, // R8
                            line_error_i}; // R9
  assign link.src_serviced = serviced_i;
  assign link.clear_all = clear_all_status; // R10

  uisc_flag_bank u_bank (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .bus(link)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  assign unlocked = (line_control_reg == UISC_UNLOCK_VAL) &&
                    special_function_reg[UISC_SFN_ENABLE_BIT]; // R1 R12
  assign status_view = {link.flags, clear_all_status};
  // accepted clear-all write; back-to-back writes keep the bit high
  assign clr_req = reg_wr_i && hit(reg_addr_i, UISC_OFS_STATUS_CLR) &&
                   unlocked && reg_wdata_i[UISC_CLR_ALL_BIT];

  always_comb begin
    next_line_control_reg = line_control_reg;
    next_special_function_reg = special_function_reg;
    next_clear_all_status = 1'b0; // R11
    next_reg_rdata = reg_rdata;
    if (reg_wr_i) begin
      if (hit(reg_addr_i, UISC_OFS_LINE_CTRL)) begin
        next_line_control_reg = reg_wdata_i;
      end
      // special function reg only reachable with unlock value
      if (hit(reg_addr_i, UISC_OFS_SPECIAL_FN) &&
          line_control_reg == UISC_UNLOCK_VAL) begin
        next_special_function_reg = reg_wdata_i;
      end
      if (hit(reg_addr_i, UISC_OFS_STATUS_CLR) && unlocked) begin // R1 R2
        next_clear_all_status = reg_wdata_i[UISC_CLR_ALL_BIT]; // R10
      end
    end
    if (reg_rd_i) begin
      next_reg_rdata = UISC_RD_ZERO;
      if (hit(reg_addr_i, UISC_OFS_LINE_CTRL)) begin
        next_reg_rdata = line_control_reg;
      end else if (hit(reg_addr_i, UISC_OFS_SPECIAL_FN) &&
                   line_control_reg == UISC_UNLOCK_VAL) begin
        next_reg_rdata = special_function_reg;
      end else if (hit(reg_addr_i, UISC_OFS_STATUS_CLR) && unlocked) begin
        next_reg_rdata = status_view; // R1 R2
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_control_reg <= UISC_LCR_RESET;
      special_function_reg <= UISC_SFN_RESET;
      clear_all_status <= UISC_STATUS_RESET[0]; // R2
      reg_rdata <= UISC_RD_ZERO;
    end else begin
      line_control_reg <= next_line_control_reg;
      special_function_reg <= next_special_function_reg;
      clear_all_status <= next_clear_all_status;
      reg_rdata <= next_reg_rdata;
    end
  end

  assign reg_rdata_o = reg_rdata;
  assign interrupt_status_clear_o = status_view;
  assign special_access_o = unlocked;

  ////////////////////////////////////////////////////////////////////////////
  property p_locked_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (reg_rd_i && hit(reg_addr_i, UISC_OFS_STATUS_CLR) && !unlocked) |=>
        (reg_rdata_o == 8'h00);
  endproperty
  a_locked_read: assert property (p_locked_read) // R1
    else $error("status register readable while locked");

  property p_locked_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (reg_wr_i && !unlocked) |=> !clear_all_status;
  endproperty
  a_locked_write: assert property (p_locked_write) // R12
    else $error("clear-all taken while locked");

  property p_unlocked_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (reg_rd_i && hit(reg_addr_i, UISC_OFS_STATUS_CLR) && unlocked) |=>
        (reg_rdata_o == $past(status_view));
  endproperty
  a_unlocked_read: assert property (p_unlocked_read) // R2
    else $error("status read mismatch");

  property p_clr_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      clr_req |=> clear_all_status;
  endproperty
  a_clr_write: assert property (p_clr_write) // R10
    else $error("clear-all write not taken");

  property p_self_clear;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (clear_all_status && !clr_req) |=> !clear_all_status;
  endproperty
  a_self_clear: assert property (p_self_clear) // R11
    else $error("clear-all bit did not self-clear");

  property p_bit7;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ($rose(cts_rts_change_i) && !clear_all_status) |=>
        interrupt_status_clear_o[7];
  endproperty
  a_bit7: assert property (p_bit7) // R3
    else $error("bit 7 missed flow-control change");

  property p_bit1;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(line_error_i) |=> interrupt_status_clear_o[1];
  endproperty
  a_bit1: assert property (p_bit1) // R9
    else $error("bit 1 missed line error");

  property p_bit4;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(transmit_holding_i) |=> interrupt_status_clear_o[4];
  endproperty
  a_bit4: assert property (p_bit4) // R6
    else $error("bit 4 missed transmit holding");

  property p_bit6;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(flow_off_special_i) |=> interrupt_status_clear_o[6];
  endproperty
  a_bit6: assert property (p_bit6) // R4
    else $error("bit 6 missed flow-off or special character");

  property p_bit5;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(modem_i) |=> interrupt_status_clear_o[5];
  endproperty
  a_bit5: assert property (p_bit5) // R5
    else $error("bit 5 missed modem status");

  property p_bit3;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(rx_timeout_i) |=> interrupt_status_clear_o[3];
  endproperty
  a_bit3: assert property (p_bit3) // R7
    else $error("bit 3 missed receiver timeout");

  property p_bit2;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(receive_holding_i) |=> interrupt_status_clear_o[2];
  endproperty
  a_bit2: assert property (p_bit2) // R8
    else $error("bit 2 missed receive holding");

  // source held low so no set edge can mask the service clear
  property p_service;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (serviced_i[2] && !rx_timeout_i) |=> !interrupt_status_clear_o[3];
  endproperty
  a_service: assert property (p_service) // R13
    else $error("timeout flag survived service");

  property p_clear_effect;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (clear_all_status && !$rose(modem_i)) |=> !interrupt_status_clear_o[5];
  endproperty
  a_clear_effect: assert property (p_clear_effect) // R10
    else $error("modem flag survived clear-all");

  c_unlock: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(unlocked));
  c_clr: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    clear_all_status);
  c_read: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_rd_i && unlocked && hit(reg_addr_i, UISC_OFS_STATUS_CLR));
endmodule // uisc_status_clear

// ===== tb/uisc_host.sv
// host processor model: single register writes and reads
`timescale 1ns/1ps
module uisc_host (
  input wire logic clk_sys_i,
  output logic [3:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 4'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one strobe cycle; released lines invert, never hold a stale value
  task automatic access(input logic [3:0] a, input logic [7:0] d,
    input logic w);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= w;
    reg_rd_o <= !w;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
endmodule // uisc_host

// ===== tb/uisc_status_clear_bench.sv
// bench: status flags, clear-all and unlock gating
`timescale 1ns/1ps
module uisc_status_clear_bench;
  import uisc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [6:0] src = 7'h00;
  logic [6:0] serv = 7'h00;
  logic [6:0] m;
  logic [3:0] addr;
  logic wr, rd, acc;
  logic [7:0] wdata, rdata, stat;
  logic [15:0] tbl [5] = '{16'hbf04, 16'hbf00, 16'hbffb, 16'h5a04, 16'hbf04};
  int failures = 0;
  int comparisons = 0;
  uisc_host uisc_host_i (.clk_sys_i(clk_sys_i), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
  uisc_status_clear uisc_status_clear_i (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .cts_rts_change_i(src[6]),
    .flow_off_special_i(src[5]), .modem_i(src[4]),
    .transmit_holding_i(src[3]), .rx_timeout_i(src[2]),
    .receive_holding_i(src[1]), .line_error_i(src[0]), .serviced_i(serv),
    .reg_rdata_o(rdata), .interrupt_status_clear_o(stat),
    .special_access_o(acc));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_stat(logic [6:0] f, logic c);
    return {f, c};
  endfunction
  function automatic logic exp_acc(logic [7:0] l, logic [7:0] s);
    return (l == UISC_UNLOCK_VAL) && s[UISC_SFN_ENABLE_BIT];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // special fn write is dropped unless line ctrl already unlocked
  task automatic unlock(input logic [7:0] l, input logic [7:0] s);
    uisc_host_i.access(UISC_OFS_LINE_CTRL, l, 1'b1);
    uisc_host_i.access(UISC_OFS_SPECIAL_FN, s, 1'b1);
    uisc_host_i.access(UISC_OFS_LINE_CTRL, 8'h00, 1'b0);
    #1;
    chk(rdata, l);
    uisc_host_i.access(UISC_OFS_SPECIAL_FN, 8'h00, 1'b0);
    #1;
    chk(rdata, (l == UISC_UNLOCK_VAL) ? s : UISC_RD_ZERO);
    tick(1);
    chk({7'h00, acc}, {7'h00, exp_acc(l, s)});
  endtask
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(38));
    #1;
    chk(stat, UISC_STATUS_RESET);
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    uisc_host_i.access(UISC_OFS_STATUS_CLR, 8'h00, 1'b0);
    #1;
    chk(rdata, UISC_RD_ZERO);
    foreach (tbl[k]) unlock(tbl[k][15:8], tbl[k][7:0]);
    for (int b = 0; b < UISC_NUM_SRC; b++) begin
      @(posedge clk_sys_i);
      src <= 7'h01 << b;
      tick(3);
      chk(stat, exp_stat(7'h01 << b, 1'b0));
      uisc_host_i.access(UISC_OFS_STATUS_CLR, 8'h00, 1'b0);
      #1;
      chk(rdata, exp_stat(7'h01 << b, 1'b0));
      @(posedge clk_sys_i);
      src <= 7'h00;
      serv <= 7'h01 << b;
      @(posedge clk_sys_i);
      serv <= 7'h00;
      tick(2);
      chk(stat, UISC_STATUS_RESET);
    end
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 7'h7f : 7'($urandom());
      @(posedge clk_sys_i);
      src <= m;
      tick(3);
      chk(stat, exp_stat(m, 1'b0));
      uisc_host_i.access(UISC_OFS_STATUS_CLR, 8'h01, 1'b1);
      #1;
      chk(stat, exp_stat(m, 1'b1));
      tick(2);
      chk(stat, UISC_STATUS_RESET);
      @(posedge clk_sys_i);
      src <= 7'h00;
    end
    // locked: clear-all write must not reach the flags
    unlock(8'h00, 8'h04);
    @(posedge clk_sys_i);
    src <= 7'h7f;
    tick(3);
    uisc_host_i.access(UISC_OFS_STATUS_CLR, 8'h01, 1'b1);
    tick(3);
    chk(stat, exp_stat(7'h7f, 1'b0));
    uisc_host_i.access(UISC_OFS_STATUS_CLR, 8'h00, 1'b0);
    #1;
    chk(rdata, UISC_RD_ZERO);
    tally_and_finish();
  end
endmodule // uisc_status_clear_bench
